// file: dv/stdr_ctl_model.sv
// scan controller model driving the serial test port
`timescale 1ns/1ns
`default_nettype none
module stdr_ctl_model (
   input wire logic clk_i,
   input wire logic tdo_i,
   output logic tck_o,
   output logic tdi_o,
   output logic ir_select_o,
   output logic capture_o,
   output logic shift_o,
   output logic update_o
);
   // test clock stands low outside frames
   initial begin
      tck_o = 1'b0;
      tdi_o = 1'b0;
      ir_select_o = 1'b0;
      capture_o = 1'b0;
      shift_o = 1'b0;
      update_o = 1'b0;
   end

   // one 160 ns test clock cycle: four system clocks low, four high;
   // tdo taken at the end of the high phase, just before the fall
   task automatic tick(output logic tdo_s);
      repeat (4) @(posedge clk_i);
      tck_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      tdo_s = tdo_i;
      tck_o <= 1'b0;
   endtask

   // capture, n shifts, update; levels change with the falling edge
   task automatic scan(input logic ir, input logic [31:0] din, input int n,
                       output logic [31:0] dout);
      logic s;
      dout = 32'h0;
      @(posedge clk_i);
      ir_select_o <= ir;
      capture_o <= 1'b1;
      tick(s);
      capture_o <= 1'b0;
      shift_o <= 1'b1;
      for (int i = 0; i < n; i++) begin
         tdi_o <= din[i];
         tick(s);
         dout[i] = s;
      end
      shift_o <= 1'b0;
      update_o <= 1'b1;
      // released data line shows the inverse
      tdi_o <= ~tdi_o;
      tick(s);
      update_o <= 1'b0;
      ir_select_o <= 1'b0;
   endtask
endmodule // stdr_ctl_model
`default_nettype wire

// file: dv/stdr_top_tb_top.sv
// self-checking bench for the scan data register block
`timescale 1ns/1ns
`default_nettype none
`include "stdr_map.svh"
`define CHECK(got, exp) begin check_count++; if ((got) !== (exp)) begin failures++; $display("Error %0t: got %h expected %h", $time, got, exp); end end
module stdr_top_tb_top;
   typedef struct packed {
      logic [2:0] code;
      logic sel;
      logic drive;
      logic ana;
      logic [7:0] dout;
   } stdr_row_type;
   localparam logic [3:0] ID_REV = 4'ha;      // arbitrary value
   localparam logic [15:0] ID_PART = 16'h5c3e; // arbitrary value
   localparam logic [10:0] ID_MAKER = 11'h2b7; // arbitrary value
   logic clk_i;
   logic reset_n_i;
   logic tck, tdi, ir_sel, cap, shf, upd, pin_tdo;
   logic tdo, tdo_oe, sel, drive, pcap, pshf, pupd, ptdi, ana;
   logic [7:0] tx, rx;
   logic [2:0] instr;
   int failures;
   int check_count;
   int cycles;
   int pcap_n;
   int pshf_n;
   int pupd_n;
   stdr_row_type rows [8];

   stdr_top #(.ID_REVISION(ID_REV), .ID_PART(ID_PART), .ID_MAKER(ID_MAKER)) uut (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .tck_i(tck), .tdi_i(tdi),
      .ir_select_i(ir_sel), .capture_i(cap), .shift_i(shf), .update_i(upd),
      .pin_scan_chain_tdo_i(pin_tdo), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
      .pin_scan_chain_sel_o(sel), .pin_scan_chain_drive_o(drive),
      .pin_scan_chain_capture_o(pcap), .pin_scan_chain_shift_o(pshf),
      .pin_scan_chain_update_o(pupd), .pin_scan_chain_tdi_o(ptdi),
      .analog_probe_active_o(ana), .analog_tx_pair_o(tx), .analog_rx_pair_o(rx),
      .instr_o(instr));

   // an undriven output line reads inverted, so a late enable shows up
   stdr_ctl_model u_ctl (.clk_i(clk_i), .tdo_i(tdo_oe ? tdo : ~tdo), .tck_o(tck), .tdi_o(tdi),
      .ir_select_o(ir_sel), .capture_o(cap), .shift_o(shf), .update_o(upd));

   // pin chain pulses counted mid-cycle, where they stand settled
   always @(negedge clk_i) begin
      pcap_n <= pcap_n + int'(pcap);
      pshf_n <= pshf_n + int'(pshf);
      pupd_n <= pupd_n + int'(pupd);
   end

   initial clk_i = 1'b0;
   always #10 clk_i = ~clk_i;

   // -------------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------------
   // expected {tx, rx} pair selection for a select code
   function automatic logic [15:0] pairs_exp(input logic [4:0] c);
      logic [7:0] one;
      one = 8'h01 << (3'h7 - c[2:0]);
      if (!c[4]) return 16'h0000;
      return c[3] ? {one, 8'h00} : {8'h00, one};
   endfunction

   task automatic settle;
      repeat (6) @(posedge clk_i);
      #1;
   endtask

   task automatic results;
      $display("Checks %0d, failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         results();
      end
   end

   // -------------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------------
   initial begin
      logic [31:0] d;
      logic [4:0] prev;
      failures = 0;
      check_count = 0;
      cycles = 0;
      reset_n_i = 1'b0;
      pin_tdo = 1'b1;
      rows[0] = '{3'h0, 1'b1, 1'b1, 1'b0, 8'hff};
      rows[1] = '{3'h1, 1'b0, 1'b0, 1'b0, 8'h64};
      rows[2] = '{3'h2, 1'b0, 1'b0, 1'b1, 8'h5f};
      rows[3] = '{3'h3, 1'b0, 1'b0, 1'b0, 8'h64};
      rows[4] = '{3'h4, 1'b1, 1'b0, 1'b0, 8'hff};
      rows[5] = '{3'h5, 1'b0, 1'b0, 1'b0, 8'h64};
      rows[6] = '{3'h6, 1'b0, 1'b0, 1'b0, {ID_MAKER[6:0], 1'b1}};
      rows[7] = '{3'h7, 1'b0, 1'b0, 1'b0, 8'h64};
      repeat (3) @(posedge clk_i);
      #1;
      `CHECK(instr, 3'h6)
      `CHECK({sel, ana, tdo_oe, tx, rx}, 19'h00000)
      @(posedge clk_i);
      reset_n_i <= 1'b1;
      settle();
      // identification read after reset
      u_ctl.scan(1'b0, 32'h0, 32, d);
      settle();
      `CHECK(d, {ID_REV, ID_PART, ID_MAKER, 1'b1})
      `CHECK(tdo_oe, 1'b0)
      // every select code, old code read back while new one loads
      u_ctl.scan(1'b1, 32'h2, 3, d);
      settle();
      `CHECK({instr, ana}, 4'h5)
      prev = 5'h00;
      for (int c = 0; c < 32; c++) begin
         u_ctl.scan(1'b0, 32'(c), 5, d);
         settle();
         `CHECK(d[4:0], prev)
         `CHECK({tx, rx}, pairs_exp(5'(c)))
         prev = 5'(c);
      end
      // instruction table, code 11111 still loaded
      for (int r = 0; r < 8; r++) begin
         u_ctl.scan(1'b1, {29'h0, rows[r].code}, 3, d);
         settle();
         `CHECK(d[2:0], 3'h1)
         `CHECK(instr, rows[r].code)
         `CHECK({sel, drive, ana}, {rows[r].sel, rows[r].drive, rows[r].ana})
         `CHECK({tx, rx}, (rows[r].code == 3'h2) ? 16'h0100 : 16'h0000)
         pcap_n = 0;
         pshf_n = 0;
         pupd_n = 0;
         u_ctl.scan(1'b0, 32'hb2, 8, d);
         settle();
         `CHECK(d[7:0], rows[r].dout)
         `CHECK({pcap_n[3:0], pshf_n[3:0], pupd_n[3:0]}, rows[r].sel ? 12'h181 : 12'h000)
         `CHECK(ptdi, tdi)
      end
      // reset in mid-run returns instruction to 110 and clears select code
      @(posedge clk_i);
      reset_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
      `CHECK({instr, ana}, 4'hc)
      @(posedge clk_i);
      reset_n_i <= 1'b1;
      settle();
      u_ctl.scan(1'b1, 32'h2, 3, d);
      settle();
      `CHECK({ana, tx, rx}, 17'h10000)
      results();
   end
endmodule // stdr_top_tb_top
`default_nettype wire

// file: hw/stdr_ana_dec.sv
// decodes the analog port select code into one-hot line pair connections
`timescale 1ns/1ns
`default_nettype none
`include "stdr_map.svh"
module stdr_ana_dec #(
   parameter int CH_N = `STDR_CHANNELS
) (
   stdr_ana_if.dec ana
);
   if (CH_N != 8) begin : g_chk
      $error("stdr_ana_dec: three code bits serve exactly eight channels");
   end

   // code 111 on the low bits is channel 0, 000 is channel 7
   for (genvar ch = 0; ch < CH_N; ch++) begin : g_ch
      localparam logic [2:0] CH_CODE = 3'(CH_N - 1 - ch);
      logic hit;
      assign hit = ana.active && ana.code[`STDR_ASR_CONNECT_BIT] && (ana.code[2:0] == CH_CODE);
      assign ana.tx_sel[ch] = hit && ana.code[`STDR_ASR_TX_BIT];
      assign ana.rx_sel[ch] = hit && !ana.code[`STDR_ASR_TX_BIT];
   end
endmodule // stdr_ana_dec
`default_nettype wire

// file: hw/stdr_ana_if.sv
// analog port select code and decoded line pair connections
`timescale 1ns/1ns
`default_nettype none
`include "stdr_map.svh"
interface stdr_ana_if;
   logic [`STDR_ASR_W-1:0] code;
   logic active;
   logic [`STDR_CHANNELS-1:0] tx_sel;
   logic [`STDR_CHANNELS-1:0] rx_sel;
   modport ctl (output code, output active, input tx_sel, input rx_sel);
   modport dec (input code, input active, output tx_sel, output rx_sel);
endinterface // stdr_ana_if
`default_nettype wire

// file: hw/stdr_map.svh
// offsets, field positions, codes and counts of the scan data registers
`ifndef STDR_MAP_SVH
`define STDR_MAP_SVH
`define STDR_IR_W 3
`define STDR_ASR_W 5
`define STDR_ID_W 32
`define STDR_CHANNELS 8
`define STDR_SYNC_W 7
`define STDR_INS_EXTEST 3'h0
`define STDR_INS_ANALOG 3'h2
`define STDR_INS_SAMPLE 3'h4
`define STDR_INS_IDCODE 3'h6
`define STDR_INS_BYPASS 3'h7
`define STDR_INS_RESET 3'h6
`define STDR_IR_CAPTURE 3'h1
`define STDR_ASR_RESET 5'h00
`define STDR_ASR_CONNECT_BIT 4
`define STDR_ASR_TX_BIT 3
`define STDR_ID_REV_LSB 28
`define STDR_ID_PART_LSB 12
`define STDR_ID_MAKER_LSB 1
`define STDR_ID_FIXED_ONE 1'h1
`endif

// file: hw/stdr_pkg.sv
// types shared by the scan data register block
package stdr_pkg;
   typedef enum logic [3:0] {
      STDR_PATH_PIN = 4'h1,
      STDR_PATH_ASR = 4'h2,
      STDR_PATH_ID  = 4'h4,
      STDR_PATH_BYP = 4'h8
   } stdr_path_type;
endpackage

// file: hw/stdr_sync.sv
// two-stage synchroniser for a group of asynchronous inputs
`timescale 1ns/1ns
`default_nettype none
module stdr_sync #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   logic [W-1:0] meta_q;

   if (W < 1) begin : g_chk
      $error("stdr_sync: width must be at least one");
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta_q <= '0;
         sync_o <= '0;
      end else begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule // stdr_sync
`default_nettype wire

// file: hw/stdr_top.sv
// instruction decode and test data registers behind the scan test port
//
// Overview of operation
// - five-bit register selects analog line pair
// - analog instruction puts select register in path
// - five test clock edges load full code
// - select code shifts in least bit first
// - codes 11111..11000 reach transmit pairs 0..7
// - codes 10111..10000 reach receive pairs 0..7
// - identification holds revision, part, maker fields
// - identification bit zero is one, lsb first
// - one-bit bypass register links input to output
// - three-bit instruction register, lsb first
// - 000 selects pin chain, drives outputs
// - 010 selects select register, enables analog
// - 100 samples pins, normal paths kept
// - 110 connects identification register to output
// - 111 routes data through bypass register
`timescale 1ns/1ns
`default_nettype none
`include "stdr_map.svh"
module stdr_top #(
   parameter logic [3:0] ID_REVISION = 4'h0,   // arbitrary value
   parameter logic [15:0] ID_PART = 16'h0000,  // arbitrary value
   parameter logic [10:0] ID_MAKER = 11'h000   // arbitrary value
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic tck_i,
   input wire logic tdi_i,
   input wire logic ir_select_i,
   input wire logic capture_i,
   input wire logic shift_i,
   input wire logic update_i,
   input wire logic pin_scan_chain_tdo_i,
   output logic tdo_o,
   output logic tdo_oe_o,
   output logic pin_scan_chain_sel_o,
   output logic pin_scan_chain_drive_o,
   output logic pin_scan_chain_capture_o,
   output logic pin_scan_chain_shift_o,
   output logic pin_scan_chain_update_o,
   output logic pin_scan_chain_tdi_o,
   output logic analog_probe_active_o,
   output logic [`STDR_CHANNELS-1:0] analog_tx_pair_o,
   output logic [`STDR_CHANNELS-1:0] analog_rx_pair_o,
   output logic [`STDR_IR_W-1:0] instr_o
);
   // ------------------------------------------------------------
   // input synchronisation and test clock edges
   // ------------------------------------------------------------
   logic [`STDR_SYNC_W-1:0] sync_s;
   logic tck_s, tdi_s, ir_sel_s, capture_s, shift_s, update_s, pin_tdo_s;
   logic tck_prev_q;
   logic tck_rise, tck_fall;

   stdr_sync #(
      .W(`STDR_SYNC_W)
   ) u_sync (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .async_i({tck_i, tdi_i, ir_select_i, capture_i, shift_i, update_i, pin_scan_chain_tdo_i}),
      .sync_o(sync_s)
   );

   assign {tck_s, tdi_s, ir_sel_s, capture_s, shift_s, update_s, pin_tdo_s} = sync_s;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tck_prev_q <= 1'h0;
      end else begin
         tck_prev_q <= tck_s;
      end
   end

   assign tck_rise = tck_s && !tck_prev_q;
   assign tck_fall = !tck_s && tck_prev_q;

   // ------------------------------------------------------------
   // instruction register
   // ------------------------------------------------------------
   logic [`STDR_IR_W-1:0] ir_sh_q;
   logic [`STDR_IR_W-1:0] instr_q;
   logic ir_step, dr_step;

   assign ir_step = tck_rise && ir_sel_s;
   assign dr_step = tck_rise && !ir_sel_s;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ir_sh_q <= `STDR_IR_CAPTURE;
      end else if (ir_step && capture_s) begin
         ir_sh_q <= `STDR_IR_CAPTURE;
      end else if (ir_step && shift_s) begin
         ir_sh_q <= {tdi_s, ir_sh_q[`STDR_IR_W-1:1]};
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         instr_q <= `STDR_INS_RESET;
      end else if (ir_step && update_s) begin
         instr_q <= ir_sh_q;
      end
   end

   // ------------------------------------------------------------
   // data path selection
   // ------------------------------------------------------------
   function automatic stdr_pkg::stdr_path_type path_of(input logic [`STDR_IR_W-1:0] ins);
      stdr_pkg::stdr_path_type p;
      p = stdr_pkg::STDR_PATH_BYP;
      if (ins == `STDR_INS_EXTEST || ins == `STDR_INS_SAMPLE) begin
         p = stdr_pkg::STDR_PATH_PIN;
      end else if (ins == `STDR_INS_ANALOG) begin
         p = stdr_pkg::STDR_PATH_ASR;
      end else if (ins == `STDR_INS_IDCODE) begin
         p = stdr_pkg::STDR_PATH_ID;
      end else begin
         p = stdr_pkg::STDR_PATH_BYP;
      end
      return p;
   endfunction

   stdr_pkg::stdr_path_type path;
   logic analog_on;

   assign path = path_of(instr_q);
   assign analog_on = (instr_q == `STDR_INS_ANALOG);

   // ------------------------------------------------------------
   // analog port select, identification and bypass registers
   // ------------------------------------------------------------
   logic [`STDR_ASR_W-1:0] asr_q;
   logic [`STDR_ID_W-1:0] id_sh_q;
   logic [`STDR_ID_W-1:0] id_value;
   logic byp_q;

   assign id_value = {ID_REVISION, ID_PART, ID_MAKER, `STDR_ID_FIXED_ONE};

   // select register, lsb first, reset disconnected
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         asr_q <= `STDR_ASR_RESET;
      end else if (dr_step && shift_s && path == stdr_pkg::STDR_PATH_ASR) begin
         asr_q <= {tdi_s, asr_q[`STDR_ASR_W-1:1]};
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         id_sh_q <= '0;
      end else if (dr_step && path == stdr_pkg::STDR_PATH_ID) begin
         if (capture_s) begin
            id_sh_q <= id_value;
         end else if (shift_s) begin
            id_sh_q <= {tdi_s, id_sh_q[`STDR_ID_W-1:1]};
         end
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         byp_q <= 1'h0;
      end else if (dr_step && path == stdr_pkg::STDR_PATH_BYP) begin
         if (capture_s) begin
            byp_q <= 1'h0;
         end else if (shift_s) begin
            byp_q <= tdi_s;
         end
      end
   end

   // ------------------------------------------------------------
   // serial output, changes on the falling test clock edge
   // ------------------------------------------------------------
   logic dr_bit;
   logic tdo_q, tdo_oe_q;

   always_comb begin
      dr_bit = byp_q;
      case (path)
         stdr_pkg::STDR_PATH_PIN: dr_bit = pin_tdo_s;
         stdr_pkg::STDR_PATH_ASR: dr_bit = asr_q[0];
         stdr_pkg::STDR_PATH_ID: dr_bit = id_sh_q[0];
         default: dr_bit = byp_q;
      endcase
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tdo_q <= 1'h0;
         tdo_oe_q <= 1'h0;
      end else if (tck_fall) begin
         tdo_q <= ir_sel_s ? ir_sh_q[0] : dr_bit;
         tdo_oe_q <= shift_s;
      end
   end

   assign tdo_o = tdo_q;
   assign tdo_oe_o = tdo_oe_q;
   assign instr_o = instr_q;

   // ------------------------------------------------------------
   // pin scan chain control
   // ------------------------------------------------------------
   logic pin_path;

   assign pin_path = (path == stdr_pkg::STDR_PATH_PIN);

   // chain select, capture and output drive
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pin_scan_chain_sel_o <= 1'h0;
         pin_scan_chain_drive_o <= 1'h0;
         pin_scan_chain_capture_o <= 1'h0;
         pin_scan_chain_shift_o <= 1'h0;
         pin_scan_chain_update_o <= 1'h0;
         pin_scan_chain_tdi_o <= 1'h0;
      end else begin
         pin_scan_chain_sel_o <= pin_path;
         pin_scan_chain_drive_o <= (instr_q == `STDR_INS_EXTEST);
         pin_scan_chain_capture_o <= dr_step && pin_path && capture_s;
         pin_scan_chain_shift_o <= dr_step && pin_path && shift_s;
         pin_scan_chain_update_o <= dr_step && pin_path && update_s;
         pin_scan_chain_tdi_o <= tdi_s;
      end
   end

   // ------------------------------------------------------------
   // analog line pair connection
   // ------------------------------------------------------------
   stdr_ana_if ana ();

   assign ana.code = asr_q;
   assign ana.active = analog_on;

   stdr_ana_dec #(
      .CH_N(`STDR_CHANNELS)
   ) u_dec (
      .ana(ana)
   );

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         analog_tx_pair_o <= '0;
         analog_rx_pair_o <= '0;
         analog_probe_active_o <= 1'h0;
      end else begin
         analog_tx_pair_o <= ana.tx_sel;
         analog_rx_pair_o <= ana.rx_sel;
         analog_probe_active_o <= analog_on;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   property p_asr_width;
      dr_step && shift_s && path == stdr_pkg::STDR_PATH_ASR
         |=> asr_q[`STDR_ASR_W-1] == $past(tdi_s);
   endproperty
   a_asr_width: assert property (p_asr_width) else $error("select code entered at wrong bit");

   property p_asr_lsb;
      dr_step && shift_s && path == stdr_pkg::STDR_PATH_ASR
         |=> asr_q == {$past(tdi_s), $past(asr_q[4:1])};
   endproperty
   a_asr_lsb: assert property (p_asr_lsb) else $error("select code not shifted lsb first");

   property p_asr_hold;
      !(dr_step && shift_s) |=> $stable(asr_q);
   endproperty
   a_asr_hold: assert property (p_asr_hold) else $error("select code changed without shift");

   property p_tx_pair;
      analog_on && asr_q[4] && asr_q[3]
         |=> analog_tx_pair_o == (8'h80 >> $past(asr_q[2:0])) && analog_rx_pair_o == 8'h00;
   endproperty
   a_tx_pair: assert property (p_tx_pair) else $error("wrong transmit pair connected");

   property p_rx_pair;
      analog_on && asr_q[4] && !asr_q[3]
         |=> analog_rx_pair_o == (8'h80 >> $past(asr_q[2:0])) && analog_tx_pair_o == 8'h00;
   endproperty
   a_rx_pair: assert property (p_rx_pair) else $error("wrong receive pair connected");

   property p_disconnect;
      !asr_q[4] || !analog_on |=> analog_tx_pair_o == 8'h00 && analog_rx_pair_o == 8'h00;
   endproperty
   a_disconnect: assert property (p_disconnect) else $error("analog pins connected");

   property p_id_capture;
      dr_step && capture_s && path == stdr_pkg::STDR_PATH_ID
         |=> id_sh_q[31:28] == ID_REVISION && id_sh_q[27:12] == ID_PART
            && id_sh_q[11:1] == ID_MAKER && id_sh_q[0];
   endproperty
   a_id_capture: assert property (p_id_capture) else $error("identification fields wrong");

   property p_tdo_path;
      tck_fall && !ir_sel_s |=> tdo_q == $past(dr_bit);
   endproperty
   a_tdo_path: assert property (p_tdo_path) else $error("selected register not on output");

   property p_id_out;
      tck_fall && !ir_sel_s && instr_q == `STDR_INS_IDCODE |=> tdo_q == $past(id_sh_q[0]);
   endproperty
   a_id_out: assert property (p_id_out) else $error("identification not on output");

   property p_bypass;
      dr_step && shift_s && !capture_s && instr_q[0] |=> byp_q == $past(tdi_s);
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass stage did not take input");

   property p_ir_lsb;
      ir_step && shift_s && !capture_s |=> ir_sh_q == {$past(tdi_s), $past(ir_sh_q[2:1])};
   endproperty
   a_ir_lsb: assert property (p_ir_lsb) else $error("instruction not shifted lsb first");

   property p_extest;
      instr_q == `STDR_INS_EXTEST |=> pin_scan_chain_sel_o && pin_scan_chain_drive_o;
   endproperty
   a_extest: assert property (p_extest) else $error("external test not driving pins");

   property p_sample;
      instr_q == `STDR_INS_SAMPLE |=> pin_scan_chain_sel_o && !pin_scan_chain_drive_o;
   endproperty
   a_sample: assert property (p_sample) else $error("sample mode disturbed pin paths");

   property p_analog_en;
      instr_q == `STDR_INS_ANALOG |=> analog_probe_active_o;
   endproperty
   a_analog_en: assert property (p_analog_en) else $error("analog probe not enabled");

   c_tx_connect: cover property (analog_tx_pair_o != 8'h00);
   c_rx_connect: cover property (analog_rx_pair_o != 8'h00);
   c_id_shift: cover property (dr_step && shift_s && path == stdr_pkg::STDR_PATH_ID);
   c_ir_update: cover property (ir_step && update_s);
endmodule // stdr_top
`default_nettype wire
